// ===== core/dcaq_qualifier.sv
// Purpose: Comparator A extension register and match qualifier
// Assumes: Core bus is synchronous to clk_i
// Notes:   Register at 0x08, base compare address at 0x0C
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "dcaq_defines.svh"

module dcaq_qualifier (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               end_trace_reset_i,
    input  wire logic               debugger_enable_i,
    input  wire logic               begin_trigger_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    output logic                    wb_err_o,
    input  wire dcaq_pkg::dcaq_bus_t core_bus_i,
    output logic                    match_o
);

    // ****************************************
    // Register decode
    // ****************************************
    logic [7:0]  ext_reg;
    logic [15:0] base_reg;
    logic        bus_req;
    logic        hit_ext;
    logic        hit_base;
    logic        wr_ok;
    logic        keep_on_reset;
    logic [31:0] rd_word;

    // Single-cycle ack; no ack while the previous one is still high
    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_ext  = (wb_adr_i == `DCAQ_OFS_EXT);
    assign hit_base = (wb_adr_i == `DCAQ_OFS_BASE);
    assign wr_ok    = bus_req && wb_we_i;
    // End-run reset preserves the extension register only in this configuration; base always clears
    assign keep_on_reset = end_trace_reset_i && debugger_enable_i && !begin_trigger_i;
    assign rd_word  = hit_ext  ? {24'h000000, ext_reg & `DCAQ_EXT_WMASK} :
                      hit_base ? {16'h0000, base_reg} : 32'h00000000;

    // Extension register; unimplemented bits never store
    always_ff @(posedge clk_i)
    begin
        if (rst_i && !keep_on_reset)
            ext_reg <= `DCAQ_EXT_RESET;
        else if (!rst_i && wr_ok && hit_ext && wb_sel_i[0])
            ext_reg <= wb_dat_i[7:0] & `DCAQ_EXT_WMASK;
    end

    // Base compare address, low sixteen bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            base_reg <= `DCAQ_BASE_RESET;
        else if (wr_ok && hit_base)
        begin
            if (wb_sel_i[0])
                base_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                base_reg[15:8] <= wb_dat_i[15:8];
        end
    end

    // Bus answer; unmapped addresses get err instead of ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req && (hit_ext || hit_base);
            wb_err_o <= bus_req && !(hit_ext || hit_base);
            wb_dat_o <= bus_req ? rd_word : 32'h00000000;
        end
    end

    // ****************************************
    // Match qualification
    // ****************************************
    logic [16:0] cmp_addr;
    logic        base_ok;
    logic        a16_ok;
    logic        page_ok;
    logic        dir_ok;
    logic        next_match;

    // Paged access forms page:addr[13:0]; else bit 16 as presented
    assign cmp_addr = core_bus_i.paged ?
                      {core_bus_i.page, core_bus_i.addr[`DCAQ_PAGE_LSB-1:0]} :
                      core_bus_i.addr;
    assign base_ok  = (cmp_addr[`DCAQ_ADDR_MSB-1:0] == base_reg);
    assign a16_ok   = (cmp_addr[`DCAQ_ADDR_MSB] == ext_reg[`DCAQ_BIT_A16]);
    assign page_ok  = (core_bus_i.paged == ext_reg[`DCAQ_BIT_PAGED]);
    // Value bit is a don't-care while qualification is off
    assign dir_ok   = !ext_reg[`DCAQ_BIT_DIR_EN] ||
                      (core_bus_i.read == ext_reg[`DCAQ_BIT_DIR_VAL]);
    assign next_match = core_bus_i.valid && base_ok && a16_ok && page_ok && dir_ok;

    // Registered so the output comes straight from a flip-flop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            match_o <= 1'b0;
        else
            match_o <= next_match;
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_dir_ignored;
        @(posedge clk_i) disable iff (rst_i)
        (!ext_reg[`DCAQ_BIT_DIR_EN] && core_bus_i.valid && base_ok && a16_ok && page_ok)
            |=> match_o;
    endproperty
    a_dir_ignored: assert property (p_dir_ignored) else $error("direction not ignored");

    property p_dir_value;
        @(posedge clk_i) disable iff (rst_i)
        (ext_reg[`DCAQ_BIT_DIR_EN] && core_bus_i.valid &&
         core_bus_i.read != ext_reg[`DCAQ_BIT_DIR_VAL]) |=> !match_o;
    endproperty
    a_dir_value: assert property (p_dir_value) else $error("wrong direction matched");

    property p_unpaged;
        @(posedge clk_i) disable iff (rst_i)
        (!ext_reg[`DCAQ_BIT_PAGED] && core_bus_i.paged) |=> !match_o;
    endproperty
    a_unpaged: assert property (p_unpaged) else $error("paged cycle matched");

    property p_paged;
        @(posedge clk_i) disable iff (rst_i)
        (ext_reg[`DCAQ_BIT_PAGED] && !core_bus_i.paged) |=> !match_o;
    endproperty
    a_paged: assert property (p_paged) else $error("unpaged cycle matched");

    property p_bit16;
        @(posedge clk_i) disable iff (rst_i)
        match_o |-> ($past(cmp_addr[`DCAQ_ADDR_MSB]) == $past(ext_reg[`DCAQ_BIT_A16]));
    endproperty
    a_bit16: assert property (p_bit16) else $error("bit 16 mismatch matched");

    property p_reset_clear;
        @(posedge clk_i) (rst_i && !keep_on_reset) |=> (ext_reg == `DCAQ_EXT_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("register not cleared");

    property p_reset_keep;
        @(posedge clk_i) (rst_i && keep_on_reset) |=> $stable(ext_reg);
    endproperty
    a_reset_keep: assert property (p_reset_keep) else $error("register lost on end run");

    property p_unimpl;
        @(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && hit_ext) |-> (wb_dat_o[`DCAQ_RSVD_MSB:`DCAQ_RSVD_LSB] == 4'h0 &&
                                   ext_reg[`DCAQ_RSVD_MSB:`DCAQ_RSVD_LSB] == 4'h0);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("reserved bits nonzero");

    property p_all_agree;
        @(posedge clk_i) disable iff (rst_i)
        match_o |-> ($past(core_bus_i.valid) && $past(base_ok) && $past(a16_ok) &&
                     $past(page_ok) && $past(dir_ok));
    endproperty
    a_all_agree: assert property (p_all_agree) else $error("match without all terms");

    // Register access: a taken request gets one answer pulse, then it drops
    sequence s_wb_taken;
        bus_req;
    endsequence

    sequence s_wb_answer;
        (wb_ack_o != wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
    endsequence

    property p_wb_answer;
        @(posedge clk_i) disable iff (rst_i)
        s_wb_taken |=> s_wb_answer;
    endproperty
    a_wb_answer: assert property (p_wb_answer) else $error("bus answer not one pulse");

    // Only the implemented bits may take the written byte
    property p_ext_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_ok && hit_ext && wb_sel_i[0]) |=>
            (ext_reg == ($past(wb_dat_i[7:0]) & `DCAQ_EXT_WMASK));
    endproperty
    a_ext_write: assert property (p_ext_write) else $error("writable bits not stored");

    property p_ext_read;
        @(posedge clk_i) disable iff (rst_i)
        (bus_req && hit_ext && !wb_we_i) |=> (wb_dat_o == {24'h000000, $past(ext_reg)});
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("extension read data wrong");

    // A wrong base address or an idle bus must never raise the match
    property p_base_miss;
        @(posedge clk_i) disable iff (rst_i)
        (core_bus_i.valid && (cmp_addr[`DCAQ_ADDR_MSB-1:0] != base_reg)) |=> !match_o;
    endproperty
    a_base_miss: assert property (p_base_miss) else $error("base mismatch matched");

    property p_match_idle;
        @(posedge clk_i) disable iff (rst_i)
        !core_bus_i.valid |=> !match_o;
    endproperty
    a_match_idle: assert property (p_match_idle) else $error("idle bus matched");

endmodule : dcaq_qualifier

// ===== core/dcaq_defines.svh
// Purpose: Constants for the comparator A extension qualifier
// Assumes: Wishbone byte addressing, 32-bit data words
// Notes:   Offsets are byte addresses
`ifndef DCAQ_DEFINES_SVH
`define DCAQ_DEFINES_SVH

`define DCAQ_ADDR_W        8
`define DCAQ_OFS_EXT       8'h08
`define DCAQ_OFS_BASE      8'h0C
`define DCAQ_BIT_DIR_EN    7
`define DCAQ_BIT_DIR_VAL   6
`define DCAQ_BIT_PAGED     5
`define DCAQ_BIT_A16       0
`define DCAQ_ADDR_MSB      16
`define DCAQ_PAGE_LSB      14
`define DCAQ_RSVD_MSB      4
`define DCAQ_RSVD_LSB      1
`define DCAQ_EXT_WMASK     8'hE1
`define DCAQ_EXT_RESET     8'h00
`define DCAQ_BASE_RESET    16'h0000

`endif

// ===== core/dcaq_pkg.sv
// Purpose: Types for the comparator A extension qualifier
// Assumes: Used with dcaq_defines.svh
// Notes:   Types only
package dcaq_pkg;
    // Snapshot of one core bus cycle
    typedef struct packed {
        logic        valid;
        logic        read;
        logic        paged;
        logic [2:0]  page;
        logic [16:0] addr;
    } dcaq_bus_t;
endpackage : dcaq_pkg

// ===== tb/dcaq_core_model.sv
// Purpose: Core bus model feeding the comparator A qualifier
// Assumes: One core cycle per clock while valid
// Notes:   Idle fields flip each cycle so stale values never match
`timescale 1ns/100ps
module dcaq_core_model (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                go_i,
    input  wire logic                read_i,
    input  wire logic                paged_i,
    input  wire logic [2:0]          page_i,
    input  wire logic [16:0]         addr_i,
    output dcaq_pkg::dcaq_bus_t      bus_o
);
    // One registered cycle per request, then released; reset keeps idle fields known
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bus_o <= '0;
        else if (go_i)
            bus_o <= {1'h1, read_i, paged_i, page_i, addr_i};
        else
            bus_o <= {1'h0, ~bus_o[21:0]};
    end
endmodule : dcaq_core_model

// ===== tb/dcaq_qualifier_tb.sv
// Purpose: Self-checking bench for the comparator A qualifier
// Assumes: Base compare address at 0x0C holds 0x1234
// Notes:   Register checks first, then match rows, then reset and unmapped cases
`timescale 1ns/100ps
`include "dcaq_defines.svh"
module dcaq_qualifier_tb;
    typedef struct packed {logic [7:0] x; logic [2:0] g; logic r, p, m; logic [16:0] a;} dcaq_row_t;
    logic clk_i, rst_i, et, dbg, bg, cyc, stb, we, go, rd, pg, ack, err, match, e;
    logic [7:0] adr;
    logic [31:0] dat, dato, q;
    logic [2:0] page;
    logic [3:0] sel, wsel;
    logic [16:0] addr;
    dcaq_pkg::dcaq_bus_t bus;
    int fail_count, checks_done;
    // Ext, page, read, paged, expected match, address
    dcaq_row_t rows[13] = '{
        '{8'h00,3'h0,1'h0,1'h0,1'h1,17'h01234}, '{8'h00,3'h0,1'h1,1'h0,1'h1,17'h01234},
        '{8'h80,3'h0,1'h0,1'h0,1'h1,17'h01234}, '{8'h80,3'h0,1'h1,1'h0,1'h0,17'h01234},
        '{8'hC0,3'h0,1'h1,1'h0,1'h1,17'h01234}, '{8'hC0,3'h0,1'h0,1'h0,1'h0,17'h01234},
        '{8'h00,3'h0,1'h0,1'h1,1'h0,17'h01234}, '{8'h20,3'h0,1'h0,1'h1,1'h1,17'h1D234},
        '{8'h20,3'h0,1'h0,1'h0,1'h0,17'h01234}, '{8'h21,3'h4,1'h0,1'h1,1'h1,17'h01234},
        '{8'h01,3'h0,1'h0,1'h0,1'h1,17'h11234}, '{8'h00,3'h0,1'h0,1'h0,1'h0,17'h11234},
        '{8'h00,3'h0,1'h0,1'h0,1'h0,17'h01235}};
    dcaq_qualifier DUT (.clk_i(clk_i), .rst_i(rst_i), .end_trace_reset_i(et),
        .debugger_enable_i(dbg), .begin_trigger_i(bg), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
        .wb_ack_o(ack), .wb_err_o(err), .core_bus_i(bus), .match_o(match));
    dcaq_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .read_i(rd),
        .paged_i(pg), .page_i(page), .addr_i(addr), .bus_o(bus));
    // Free-running clock
    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x)
        begin
            $display("mismatch %s exp %h got %h", n, x, g);
            fail_count++;
        end
    endtask : chk
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // Classic cycle held until ack or err is sampled; bounded wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {1'h1, 1'h1, w, a, d, wsel};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && err !== 1'h1 && n < 20);
        q = dato;
        e = err;
        {cyc, stb} <= 2'h0;
        if (n >= 20)
        begin
            fail_count++;
            conclude();
        end
    endtask : wb
    task rst(input logic a, input logic b, input logic c);
        @(posedge clk_i);
        {rst_i, et, dbg, bg} <= {1'h1, a, b, c};
        repeat (2) @(posedge clk_i);
        {rst_i, et} <= 2'h0;
    endtask : rst
    initial
    begin
        {rst_i, et, dbg, bg, cyc, stb, we, go, rd, pg} = 10'h200;
        {adr, dat, page, addr} = '0;
        {sel, wsel} = 8'hFF;
        fail_count = 0;
        checks_done = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, `DCAQ_OFS_EXT, 32'h0);
        chk("ext reset", q, 32'h0);
        wb(1'h1, `DCAQ_OFS_EXT, 32'hFF);
        wb(1'h0, `DCAQ_OFS_EXT, 32'h0);
        chk("ext bits", q, 32'hE1);
        // Lane 0 off: the extension byte must not change
        wsel = 4'hE;
        wb(1'h1, `DCAQ_OFS_EXT, 32'h00);
        wsel = 4'hF;
        wb(1'h0, `DCAQ_OFS_EXT, 32'h0);
        chk("ext lane", q, 32'hE1);
        wb(1'h1, `DCAQ_OFS_BASE, 32'h1234);
        wb(1'h0, `DCAQ_OFS_BASE, 32'h0);
        chk("base", q, 32'h1234);
        $display("register test done");
        // One core cycle per row, checked against the row's expected match
        foreach (rows[i])
        begin
            wb(1'h1, `DCAQ_OFS_EXT, {24'h0, rows[i].x});
            @(posedge clk_i);
            {go, rd, pg, page, addr} <= {1'h1, rows[i].r, rows[i].p, rows[i].g, rows[i].a};
            @(posedge clk_i);
            go <= 1'h0;
            @(posedge clk_i);
            #1 chk("match", 32'(match), 32'(rows[i].m));
        end
        $display("match test done");
        wb(1'h1, `DCAQ_OFS_EXT, 32'hE1);
        rst(1'h1, 1'h1, 1'h0);
        wb(1'h0, `DCAQ_OFS_EXT, 32'h0);
        chk("ext kept", q, 32'hE1);
        wb(1'h0, `DCAQ_OFS_BASE, 32'h0);
        chk("base cleared", q, 32'h0);
        rst(1'h1, 1'h1, 1'h1);
        wb(1'h0, `DCAQ_OFS_EXT, 32'h0);
        chk("ext cleared", q, 32'h0);
        wb(1'h1, `DCAQ_OFS_EXT, 32'hE1);
        rst(1'h1, 1'h0, 1'h0);
        wb(1'h0, `DCAQ_OFS_EXT, 32'h0);
        chk("ext no debugger", q, 32'h0);
        wb(1'h1, `DCAQ_OFS_EXT, 32'hE1);
        rst(1'h0, 1'h1, 1'h0);
        wb(1'h0, `DCAQ_OFS_EXT, 32'h0);
        chk("ext plain reset", q, 32'h0);
        $display("reset test done");
        wb(1'h0, 8'h10, 32'h0);
        chk("unmapped err", 32'(e), 32'h1);
        chk("unmapped data", q, 32'h0);
        $display("unmapped test done");
        conclude();
    end
endmodule : dcaq_qualifier_tb
